// file: eac_counter.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// small show-ahead fifo with a registered output stage
module eac_fifo #(
	parameter int WIDTH = eac_pkg::CNT_W,
	parameter int DEPTH = eac_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] cnt_ff;
	logic [WIDTH-1:0] dout_ff;
	logic dvalid_ff;
	logic push;
	logic pop;

	// full is honest: the output stage does not count as storage
	assign in_ready = cnt_ff < (AW+1)'(DEPTH);
	assign push = in_valid & in_ready;
	// refill the output stage when it is empty or being taken
	assign pop = (cnt_ff != '0) & (~dvalid_ff | out_ready);
	assign out_valid = dvalid_ff;
	assign out_data = dout_ff;

	// storage write; no reset needed on the data array
	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	// pointers wrap naturally since depth is a power of two
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
		end
	end

	// fill level
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_ff <= '0;
		end else if (push && !pop) begin
			cnt_ff <= cnt_ff + 1'b1;
		end else if (pop && !push) begin
			cnt_ff <= cnt_ff - 1'b1;
		end
	end

	// output register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dvalid_ff <= 1'b0;
			dout_ff <= '0;
		end else if (pop) begin
			dvalid_ff <= 1'b1;
			dout_ff <= mem_ff[rd_ptr_ff];
		end else if (out_ready) begin
			dvalid_ff <= 1'b0;
		end
	end
endmodule : eac_fifo

////////////////////////////////////////////////////////////////////////////////
// Function
// (R01) with index gating on, nothing counts until an index edge arrives
// (R02) without gating, counting starts right at measurement start
// (R03) index comes through the first channel's comparator, same as its threshold
// (R04) gated and no index ever: every interval reports zero
// (R05) events mode reports rising edges per interval, up to about 500 kHz
// (R06) one event is one rising edge of the conditioned input
// (R07) differential distance: interval displacement scaled by pulses per meter
// (R08) absolute distance: running sum of scaled intervals from start or index
// (R09) differential angle: interval rotation scaled by pulses per revolution
// (R10) absolute angle: running sum, zeroed at index, else zero at start
// (R11) summed angle: index honoured once, sum may pass one revolution
// (R12) signed 16-bit interval counter, overflow past 32767 flagged
// (R13) dual track counts four edges per period, limit 8192 pulses per rev
// (R14) quadrature phase gives the sign of each counted edge
// (R15) tick latches the interval count and restarts it, no edge lost
module eac_counter (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic meas_run,
	input wire logic index_gate_en,
	input wire logic dual_track,
	input wire eac_pkg::eac_mode_t mode,
	input wire logic [15:0] pulses_per_unit,
	input wire logic [15:0] scale_factor,
	input wire logic sample_tick,
	input wire logic track_a_pin,
	input wire logic track_b_pin,
	input wire logic index_pin,
	input wire logic out_ready,
	output logic out_valid,
	output logic [15:0] out_data,
	output logic counting,
	output logic overflow,
	output logic config_err
);
	logic [2:0] sync1_ff;
	logic [2:0] sync2_ff;
	logic [2:0] sync3_ff;
	logic [2:0] filt_ff;
	logic [2:0] nxt_filt;
	logic run_prev_ff;
	logic counting_ff;
	logic tick_pend_ff;
	logic ovf_ff;
	logic cfg_err_ff;
	logic signed [15:0] diff_cnt_ff;
	logic signed [15:0] acc_ff;
	logic signed [1:0] qd;
	logic signed [15:0] delta16;
	logic signed [15:0] sum;
	logic signed [15:0] scaled;
	logic [15:0] push_data;
	logic run_rise;
	logic idx_rise;
	logic a_rise;
	logic tick_req;
	logic fifo_ready;
	logic push;
	logic ovf_w;
	logic abs_mode;

	// quadrature step: a leads b is forward (00,10,11,01)
	function automatic logic signed [1:0] qdec(input logic [1:0] ab_old, input logic [1:0] ab_new);
		logic signed [1:0] r;
		r = 2'sb00;
		case ({ab_old, ab_new})
			4'h2, 4'hb, 4'hd, 4'h4: r = 2'sb01;
			4'h1, 4'h7, 4'he, 4'h8: r = -2'sb01;
			default: r = 2'sb00;
		endcase
		return r;
	endfunction : qdec

	// fixed-point multiply of a count by the unit scale
	function automatic logic signed [15:0] scale_val(input logic signed [15:0] v, input logic [15:0] k);
		logic signed [32:0] p;
		p = v * $signed({1'b0, k});
		return p[eac_pkg::SCALE_SHIFT +: 16];
	endfunction : scale_val

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers; a level is accepted once stages two and three agree
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1_ff <= eac_pkg::PIN_RST;
			sync2_ff <= eac_pkg::PIN_RST;
			sync3_ff <= eac_pkg::PIN_RST;
		end else begin
			sync1_ff <= {index_pin, track_b_pin, track_a_pin}; // R03
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	// keep old level while the two late stages disagree, which rejects one-cycle glitches
	assign nxt_filt = (sync2_ff & sync3_ff) | (filt_ff & (sync2_ff ^ sync3_ff));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			filt_ff <= eac_pkg::PIN_RST;
		end else begin
			filt_ff <= nxt_filt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// edge and event decoding
	assign run_rise = meas_run & ~run_prev_ff;
	assign idx_rise = nxt_filt[eac_pkg::PIN_IDX] & ~filt_ff[eac_pkg::PIN_IDX];
	assign a_rise = nxt_filt[eac_pkg::PIN_A] & ~filt_ff[eac_pkg::PIN_A]; // R06
	assign qd = qdec({filt_ff[eac_pkg::PIN_A], filt_ff[eac_pkg::PIN_B]},
		{nxt_filt[eac_pkg::PIN_A], nxt_filt[eac_pkg::PIN_B]}); // R14

	// per-cycle count step; events are always positive, single track counts up
	always_comb begin
		delta16 = 16'sh0000;
		if (mode == eac_pkg::EAC_EVENTS || !dual_track) begin
			delta16 = a_rise ? 16'sh0001 : 16'sh0000; // R05 R06
		end else begin
			delta16 = 16'(qd); // R13 R14
		end
	end

	assign abs_mode = (mode == eac_pkg::EAC_DIST_ABS) || (mode == eac_pkg::EAC_ANG_ABS) ||
		(mode == eac_pkg::EAC_ANG_SUM);
	// the edge of this very cycle is folded into the emitted sample
	assign sum = diff_cnt_ff + delta16; // R15
	assign ovf_w = counting_ff && (diff_cnt_ff[15] == delta16[15]) && (sum[15] != diff_cnt_ff[15]); // R12
	assign scaled = scale_val(sum, scale_factor); // R07 R09

	// a full buffer defers the tick: the interval simply stretches, nothing is dropped
	assign tick_req = sample_tick | tick_pend_ff;
	assign push = tick_req & fifo_ready;

	// value of the interval that is closing
	always_comb begin
		push_data = 16'h0000;
		if (!counting_ff) begin
			push_data = 16'h0000; // R04
		end else begin
			case (mode)
				eac_pkg::EAC_EVENTS: push_data = sum; // R05
				eac_pkg::EAC_DIST_DIFF: push_data = scaled; // R07
				eac_pkg::EAC_ANG_DIFF: push_data = scaled; // R09
				eac_pkg::EAC_DIST_ABS: push_data = 16'(acc_ff + scaled); // R08
				eac_pkg::EAC_ANG_ABS: push_data = 16'(acc_ff + scaled); // R10
				eac_pkg::EAC_ANG_SUM: push_data = 16'(acc_ff + scaled); // R11
				default: push_data = 16'h0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// measurement start and index gating
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			run_prev_ff <= 1'b0;
		end else begin
			run_prev_ff <= meas_run;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			counting_ff <= 1'b0;
		end else if (!meas_run) begin
			counting_ff <= 1'b0;
		end else if (run_rise && !index_gate_en) begin
			counting_ff <= 1'b1; // R02
		end else if (index_gate_en && idx_rise) begin
			counting_ff <= 1'b1; // R01
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interval counter; wraps on overflow, the flag tells software
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			diff_cnt_ff <= 16'sh0000;
		end else if (!counting_ff) begin
			diff_cnt_ff <= 16'sh0000; // R01
		end else if (push) begin
			diff_cnt_ff <= 16'sh0000; // R15
		end else if (mode == eac_pkg::EAC_ANG_ABS && idx_rise) begin
			diff_cnt_ff <= 16'sh0000; // R10
		end else begin
			diff_cnt_ff <= sum; // R12
		end
	end

	// running position for the absolute and summed modes
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			acc_ff <= 16'sh0000;
		end else if (!counting_ff) begin
			acc_ff <= 16'sh0000; // R08 R10
		end else if (mode == eac_pkg::EAC_ANG_ABS && idx_rise) begin
			acc_ff <= 16'sh0000; // R10
		end else if (push && abs_mode) begin
			acc_ff <= 16'(acc_ff + scaled); // R08 R11
		end
	end

	// a deferred tick waits here until the buffer takes it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tick_pend_ff <= 1'b0;
		end else begin
			tick_pend_ff <= tick_req & ~push; // R15
		end
	end

	// sticky overflow, cleared at the next start; a set in that cycle wins
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ovf_ff <= 1'b0;
		end else if (ovf_w) begin
			ovf_ff <= 1'b1; // R12
		end else if (run_rise) begin
			ovf_ff <= 1'b0;
		end
	end

	// x4 decoding only fits encoders up to the limit
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg_err_ff <= 1'b0;
		end else begin
			cfg_err_ff <= dual_track && (mode != eac_pkg::EAC_EVENTS) &&
				(pulses_per_unit > eac_pkg::MAX_PPR_DUAL); // R13
		end
	end

	assign counting = counting_ff;
	assign overflow = ovf_ff;
	assign config_err = cfg_err_ff;

	////////////////////////////////////////////////////////////////////////////
	// output buffer
	eac_fifo #(
		.WIDTH(16),
		.DEPTH(eac_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(tick_req),
		.in_ready(fifo_ready),
		.in_data(push_data),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(out_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// checks
	property p_gate_hold;
		@(posedge clk) disable iff (!rst_n)
		meas_run && index_gate_en && !counting_ff && !idx_rise |=> !counting_ff;
	endproperty
	a_gate_hold: assert property (p_gate_hold) else $error("started without index"); // R01

	property p_nogate_start;
		@(posedge clk) disable iff (!rst_n)
		run_rise && !index_gate_en ##1 meas_run |-> counting_ff;
	endproperty
	a_nogate_start: assert property (p_nogate_start) else $error("ungated start late"); // R02

	property p_idle_zero;
		@(posedge clk) disable iff (!rst_n)
		push && !counting_ff |-> push_data == 16'h0000;
	endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("idle sample not zero"); // R04

	property p_evt_pos;
		@(posedge clk) disable iff (!rst_n)
		mode == eac_pkg::EAC_EVENTS && counting_ff && !push && !a_rise && $past(counting_ff)
			|=> diff_cnt_ff == $past(diff_cnt_ff);
	endproperty
	a_evt_pos: assert property (p_evt_pos) else $error("event counted without rising edge"); // R06

	property p_restart;
		@(posedge clk) disable iff (!rst_n)
		push && counting_ff ##1 counting_ff && !push && mode != eac_pkg::EAC_ANG_ABS
			|=> diff_cnt_ff == $past(delta16);
	endproperty
	a_restart: assert property (p_restart) else $error("interval not restarted at tick"); // R15

	property p_ovf;
		@(posedge clk) disable iff (!rst_n)
		counting_ff && diff_cnt_ff == eac_pkg::CNT_MAX && delta16 == 16'sh0001 |=> ovf_ff;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow not flagged"); // R12

	property p_quad_fwd;
		@(posedge clk) disable iff (!rst_n)
		dual_track && mode == eac_pkg::EAC_DIST_DIFF && counting_ff && !push &&
			filt_ff[1:0] == 2'h0 && nxt_filt[1:0] == 2'h1
			|=> diff_cnt_ff == 16'($past(diff_cnt_ff) + 16'sh0001);
	endproperty
	a_quad_fwd: assert property (p_quad_fwd) else $error("forward step not counted up"); // R14

	property p_sum_once;
		@(posedge clk) disable iff (!rst_n)
		mode == eac_pkg::EAC_ANG_SUM && counting_ff && idx_rise && !push && meas_run
			|=> acc_ff == $past(acc_ff);
	endproperty
	a_sum_once: assert property (p_sum_once) else $error("summed angle reset by index"); // R11

	property p_ppr_limit;
		@(posedge clk) disable iff (!rst_n)
		dual_track && mode != eac_pkg::EAC_EVENTS && pulses_per_unit > eac_pkg::MAX_PPR_DUAL |=> cfg_err_ff;
	endproperty
	a_ppr_limit: assert property (p_ppr_limit) else $error("resolution limit not flagged"); // R13
endmodule : eac_counter

`default_nettype wire

// file: eac_counter_tb.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module eac_counter_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic meas_run = 1'b0;
	logic index_gate_en = 1'b0;
	logic dual_track = 1'b0;
	eac_pkg::eac_mode_t mode = eac_pkg::EAC_EVENTS;
	logic [15:0] pulses_per_unit = 16'h0400;
	logic [15:0] scale_factor = 16'h0100;
	logic sample_tick = 1'b0;
	logic out_ready = 1'b0;
	logic track_a, track_b, index_pin, out_valid, counting, overflow, config_err;
	logic [15:0] out_data;
	int fails = 0;
	int comparisons = 0;

	// 200 MHz clock
	initial forever #2.5 clk = ~clk;

	eac_enc_model enc (.clk(clk), .track_a(track_a), .track_b(track_b), .index(index_pin));

	eac_counter uut (.clk(clk), .rst_n(rst_n), .meas_run(meas_run), .index_gate_en(index_gate_en),
		.dual_track(dual_track), .mode(mode), .pulses_per_unit(pulses_per_unit),
		.scale_factor(scale_factor), .sample_tick(sample_tick), .track_a_pin(track_a),
		.track_b_pin(track_b), .index_pin(index_pin), .out_ready(out_ready), .out_valid(out_valid),
		.out_data(out_data), .counting(counting), .overflow(overflow), .config_err(config_err));

	////////////////////////////////////////////////////////////////////////////////
	// inputs always move 1 ns after the rising edge, never on it
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk16

	task automatic chk1(input logic got, input logic exp);
		chk16({15'h0000, got}, {15'h0000, exp});
	endtask : chk1

	task automatic tick();
		sample_tick = 1'b1;
		cyc(1);
		sample_tick = 1'b0;
	endtask : tick

	// waits a bounded time for a word, compares it, then pops it with one ready edge
	task automatic get(input logic [15:0] exp);
		for (int i = 0; i < 20 && out_valid !== 1'b1; i++) cyc(1);
		chk1(out_valid, 1'b1);
		chk16(out_data, exp);
		out_ready = 1'b1;
		cyc(1);
		out_ready = 1'b0;
	endtask : get

	task automatic smp(input logic [15:0] exp);
		tick();
		get(exp);
	endtask : smp

	// a low phase of meas_run clears the count and the running sum before each test
	task automatic start(input eac_pkg::eac_mode_t m, input logic gate, input logic dual, input logic [15:0] sc);
		meas_run = 1'b0;
		mode = m;
		index_gate_en = gate;
		dual_track = dual;
		scale_factor = sc;
		cyc(2);
		meas_run = 1'b1;
		cyc(2);
	endtask : start

	task automatic done(input string name);
		$display("test %s done", name);
	endtask : done

	task automatic finish_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test

	////////////////////////////////////////////////////////////////////////////////
	// the whole run is some 620 clocks; the limit leaves wide room
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		finish_test();
	end

	initial begin
		cyc(4);
		rst_n = 1'b1;
		cyc(6);
		start(eac_pkg::EAC_EVENTS, 1'b0, 1'b0, 16'h0100);
		chk1(counting, 1'b1);
		enc.step(20, 1'b0);
		smp(16'h0005);
		smp(16'h0000);
		done("events");
		start(eac_pkg::EAC_EVENTS, 1'b1, 1'b0, 16'h0100);
		enc.step(8, 1'b0);
		smp(16'h0000);
		chk1(counting, 1'b0);
		enc.pulse_index();
		chk1(counting, 1'b1);
		enc.step(12, 1'b0);
		smp(16'h0003);
		done("gate");
		start(eac_pkg::EAC_DIST_DIFF, 1'b0, 1'b1, 16'h0180);
		enc.step(8, 1'b0);
		smp(16'h000c);
		enc.step(4, 1'b1);
		smp(16'hfffa);
		done("dist_diff");
		start(eac_pkg::EAC_DIST_ABS, 1'b0, 1'b1, 16'h0100);
		enc.step(3, 1'b0);
		smp(16'h0003);
		enc.step(5, 1'b1);
		smp(16'hfffe);
		enc.pulse_index();
		enc.step(1, 1'b0);
		smp(16'hffff);
		done("dist_abs");
		start(eac_pkg::EAC_ANG_DIFF, 1'b0, 1'b1, 16'h0200);
		enc.step(5, 1'b0);
		smp(16'h000a);
		done("ang_diff");
		start(eac_pkg::EAC_ANG_ABS, 1'b0, 1'b1, 16'h0100);
		enc.step(4, 1'b0);
		smp(16'h0004);
		enc.step(4, 1'b0);
		smp(16'h0008);
		enc.pulse_index();
		enc.step(2, 1'b0);
		smp(16'h0002);
		done("ang_abs");
		start(eac_pkg::EAC_ANG_SUM, 1'b1, 1'b1, 16'h0100);
		enc.step(2, 1'b0);
		smp(16'h0000);
		enc.pulse_index();
		enc.step(4, 1'b0);
		smp(16'h0004);
		enc.pulse_index();
		enc.step(4, 1'b0);
		smp(16'h0008);
		chk1(overflow, 1'b0);
		done("ang_sum");
		// four words stored plus the output stage: the sixth tick waits and keeps counting, nothing is lost
		start(eac_pkg::EAC_EVENTS, 1'b0, 1'b0, 16'h0100);
		for (int i = 0; i < 5; i++) begin
			enc.step(4, 1'b0);
			tick();
		end
		enc.step(8, 1'b0);
		tick();
		enc.step(4, 1'b0);
		for (int i = 0; i < 5; i++) get(16'h0001);
		get(16'h0003);
		cyc(4);
		chk1(out_valid, 1'b0);
		done("fifo");
		// resolution limit for dual track, just above and at the limit
		mode = eac_pkg::EAC_DIST_DIFF;
		dual_track = 1'b1;
		pulses_per_unit = 16'h2001;
		cyc(3);
		chk1(config_err, 1'b1);
		pulses_per_unit = 16'h2000;
		cyc(3);
		chk1(config_err, 1'b0);
		done("limit");
		finish_test();
	end
endmodule : eac_counter_tb

`default_nettype wire

// file: eac_enc_model.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// quadrature encoder with index; each pin state is held 4 clocks, twice the minimum
module eac_enc_model (
	input wire logic clk,
	output logic track_a,
	output logic track_b,
	output logic index
);
	logic [1:0] phase = 2'h0;

	// gray order 00,10,11,01: track a leads track b when moving forward
	assign track_a = (phase == 2'h1) || (phase == 2'h2);
	assign track_b = phase[1];
	initial index = 1'b0;

	task automatic hold();
		repeat (4) @(posedge clk);
		#1;
	endtask : hold

	// n quadrature edges; four of them give one rising edge on track a
	task automatic step(input int n, input bit rev);
		for (int i = 0; i < n; i++) begin
			phase = rev ? phase - 2'h1 : phase + 2'h1;
			hold();
		end
	endtask : step

	// the index only ever rises on its own pin, never on the tracks
	task automatic pulse_index();
		index = 1'b1;
		hold();
		index = 1'b0;
		hold();
	endtask : pulse_index
endmodule : eac_enc_model

`default_nettype wire

// file: eac_pkg.sv
package eac_pkg;
	// counter geometry
	localparam int CNT_W = 16;
	localparam logic signed [15:0] CNT_MAX = 16'sh7fff;
	// fixed-point scaling: value = count * scale_factor >>> SCALE_SHIFT
	localparam int SCALE_SHIFT = 8;
	// largest encoder resolution that the 16-bit count carries with x4 decoding
	localparam logic [15:0] MAX_PPR_DUAL = 16'h2000;
	// output buffer depth, must be a power of two
	localparam int FIFO_DEPTH = 4;
	// clock and the fastest event rate that must be followed
	localparam int CLK_FREQ_KHZ = 200000;
	localparam int EVT_MAX_KHZ = 500;
	// least clock cycles between two events at the top rate (rounded down)
	localparam int EVT_MIN_CYC = CLK_FREQ_KHZ / EVT_MAX_KHZ;
	// synchroniser bits for {index, track b, track a}
	localparam int PIN_A = 0;
	localparam int PIN_B = 1;
	localparam int PIN_IDX = 2;
	localparam logic [2:0] PIN_RST = 3'h0;

	// measurement modes
	typedef enum logic [2:0] {
		EAC_EVENTS,
		EAC_DIST_DIFF,
		EAC_DIST_ABS,
		EAC_ANG_DIFF,
		EAC_ANG_ABS,
		EAC_ANG_SUM
	} eac_mode_t;
endpackage : eac_pkg
